/* File: rtl/nfi_top.sv */
// Purpose: fifo, transfer word counter and event status part of a nand flash controller
// Assumes: inputs synchronous to mclk; flash ready already synchronised
// Notes: register bus is an APB-style slave with zero wait states
// Operation
// - strobe end with word counter just reaching zero sets event bit 2
// - every strobe end sets event bit 1
// - each strobe lasts 3 to 33 clocks, chosen by configuration
// - seven mask bits, 1 blocks the request, reset to 1
// - bus write to fifo port pushes one word
// - write while 36 words held and no word popped that cycle is dropped and flags fifo error
// - bus read of fifo port pops and returns one word
// - read while empty is ignored and flags fifo error
// - word counter zero disables transfer, non-zero means transfer running
// - writing 1 to clear bit n resets event flag n; 0 does nothing
// - test bit 1 blocks internal controller access to the fifo
// - test bit 0 inverts data at fifo input and output
// - fifo error locks the fifo until a fifo reset
`timescale 1ns/10ps
module nfi_top (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [nfi_pkg::ADDR_W-1:0] paddr,
    input wire logic [nfi_pkg::DATA_W-1:0] pwdata,
    output logic [nfi_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fifo_clear,
    input wire logic xfer_write,
    input wire logic [nfi_pkg::STROBE_CFG_W-1:0] strobe_cfg,
    input wire logic flash_ready_sync,
    input wire logic [nfi_pkg::DATA_W-1:0] flash_rdata,
    output logic [nfi_pkg::DATA_W-1:0] flash_wdata,
    output logic rw_strobe_n,
    output logic words_busy,
    output logic nand_irq
);
    import nfi_pkg::*;

    // bus decode
    logic acc, bus_wr, bus_rd, mapped;
    logic bus_push, bus_pop, wr_mask, wr_words, wr_clear, wr_test;

    assign acc = psel && penable;
    assign bus_wr = acc && pwrite;
    assign bus_rd = acc && !pwrite;
    assign mapped = (paddr == OFS_STATUS) || (paddr == OFS_MASK) || (paddr == OFS_FIFO) ||
                    (paddr == OFS_WORDS) || (paddr == OFS_CLEAR) || (paddr == OFS_TEST);
    // zero wait states
    assign pready = 1'b1;
    // unmapped: error, no effect
    assign pslverr = acc && !mapped;
    assign bus_push = bus_wr && (paddr == OFS_FIFO);
    assign bus_pop = bus_rd && (paddr == OFS_FIFO);
    assign wr_mask = bus_wr && (paddr == OFS_MASK);
    assign wr_words = bus_wr && (paddr == OFS_WORDS);
    assign wr_clear = bus_wr && (paddr == OFS_CLEAR);
    assign wr_test = bus_wr && (paddr == OFS_TEST);

    // software registers
    logic [EVT_N-1:0] mask_reg, mask_next;
    logic [1:0] test_reg, test_next;
    logic [DATA_W-1:0] words_reg, words_next;
    logic block, invert;

    assign block = test_reg[TEST_BLOCK];
    assign invert = test_reg[TEST_INVERT];

    // fifo and buffer wiring
    logic [DATA_W-1:0] fifo_wdata, fifo_rdata, fifo_out;
    logic [CNT_W-1:0] fifo_cnt;
    logic fifo_err, fifo_locked, fifo_empty, fifo_full;
    logic int_push, int_pop, int_pop_cand;
    logic buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
    logic [DATA_W-1:0] buf_in_data, buf_out_data;

    // strobe engine
    nfi_state_t state_reg, state_next;
    logic [5:0] scnt_reg, scnt_next, strobe_len;
    logic strobe_n_reg, strobe_n_next;
    logic go, strobe_end;

    assign fifo_empty = (fifo_cnt == '0);
    assign fifo_full = (fifo_cnt == CNT_FULL);
    // inverted on both memory sides
    assign fifo_out = fifo_rdata ^ {DATA_W{invert}};

    // bus accesses win; the internal path waits
    // write: fifo to buffer; read: buffer to fifo
    assign int_pop_cand = xfer_write && !block && !bus_pop && !fifo_empty && !fifo_locked;
    assign int_pop = int_pop_cand && buf_in_ready;
    assign int_push = !xfer_write && !block && !bus_push && buf_out_valid && !fifo_full &&
                      !fifo_locked;
    assign fifo_wdata = (bus_push ? pwdata : buf_out_data) ^ {DATA_W{invert}};

    // each strobe end moves one word
    assign buf_in_valid = xfer_write ? int_pop_cand : strobe_end;
    assign buf_in_data = xfer_write ? fifo_out : flash_rdata;
    assign buf_out_ready = xfer_write ? strobe_end : int_push;

    nfi_fifo u_fifo (
        .mclk(mclk),
        .reset_n(reset_n),
        .clear(fifo_clear),
        .push(bus_push || int_push),
        .pop(bus_pop || int_pop),
        .wdata(fifo_wdata),
        .rdata(fifo_rdata),
        .count(fifo_cnt),
        .error_pulse(fifo_err),
        .locked(fifo_locked)
    );

    // absorbs a stall on either side
    nfi_buf u_buf (
        .mclk(mclk),
        .reset_n(reset_n),
        .flush(fifo_clear),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data(buf_in_data),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_out_data)
    );

    // strobe length clamped to the legal window
    always_comb begin
        strobe_len = STROBE_MIN + {1'b0, strobe_cfg};
        if (strobe_len > STROBE_MAX) begin
            strobe_len = STROBE_MAX;
        end
    end

    // a word moves only while the counter is non-zero and the far side can take it
    assign go = (words_reg != '0) && flash_ready_sync && !block &&
                (xfer_write ? buf_out_valid : buf_in_ready);
    assign strobe_end = (state_reg == NFI_STROBE) && (scnt_reg == 6'h00);

    always_comb begin
        state_next = state_reg;
        scnt_next = scnt_reg;
        case (state_reg)
            NFI_IDLE: begin
                if (go) begin
                    state_next = NFI_STROBE;
                    scnt_next = strobe_len - 6'h01;
                end
            end
            NFI_STROBE: begin
                if (scnt_reg == 6'h00) begin
                    state_next = NFI_GAP;
                end else begin
                    scnt_next = scnt_reg - 6'h01;
                end
            end
            // gap keeps strobes two cycles apart
            NFI_GAP: begin
                state_next = NFI_IDLE;
            end
            default: begin
                state_next = NFI_IDLE;
                scnt_next = 6'h00;
            end
        endcase
        // strobe level leaves a flop
        strobe_n_next = (state_next != NFI_STROBE);
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= NFI_IDLE;
            scnt_reg <= 6'h00;
            strobe_n_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            scnt_reg <= scnt_next;
            strobe_n_reg <= strobe_n_next;
        end
    end

    assign rw_strobe_n = strobe_n_reg;
    assign flash_wdata = buf_out_data;

    // software register group
    always_comb begin
        mask_next = wr_mask ? pwdata[EVT_N-1:0] : mask_reg;
        test_next = wr_test ? pwdata[1:0] : test_reg;
        words_next = words_reg;
        // a bus write wins
        if (wr_words) begin
            words_next = pwdata;
        end else if (strobe_end && (words_reg != '0)) begin
            // zero never wraps on a mid-strobe abort
            words_next = words_reg - 32'h0000_0001;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mask_reg <= MASK_RESET;
            test_reg <= TEST_RESET;
            words_reg <= WORDS_RESET;
        end else begin
            mask_reg <= mask_next;
            test_reg <= test_next;
            words_reg <= words_next;
        end
    end

    assign words_busy = (words_reg != '0);

    // event detection
    logic fr_prev_reg, fr_prev_next;
    logic [CNT_W-1:0] cnt_prev_reg, cnt_prev_next;
    logic [EVT_N-1:0] ev, flag_reg, flag_next;
    logic irq_reg, irq_next;
    logic burst_left;

    // level events compare with last count
    assign burst_left = (words_reg > BURST_WORDS);
    assign cnt_prev_next = fifo_cnt;
    assign fr_prev_next = flash_ready_sync;

    always_comb begin
        ev = '0;
        ev[EV_FLASH_RDY] = flash_ready_sync && !fr_prev_reg;
        ev[EV_STROBE_RDY] = strobe_end;
        // a same-cycle counter write ends no burst
        ev[EV_EMPTY_RDY] = strobe_end && (words_reg == 32'h0000_0001) && !wr_words;
        ev[EV_LOW] = ((fifo_cnt == '0) && (cnt_prev_reg != '0)) ||
                     ((fifo_cnt == CNT_AEMPTY) && (cnt_prev_reg == CNT_LOW_FROM) && burst_left);
        ev[EV_HIGH] = ((fifo_cnt == CNT_FULL) && (cnt_prev_reg != CNT_FULL)) ||
                      ((fifo_cnt == CNT_AFULL) && (cnt_prev_reg == CNT_HIGH_FROM) && burst_left);
        ev[EV_FULL] = (fifo_cnt == CNT_FULL) && (cnt_prev_reg != CNT_FULL);
        ev[EV_ERR] = fifo_err;
    end

    // set wins over a write-one clear in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < EVT_N; gi = gi + 1) begin : g_flag
            assign flag_next[gi] = ev[gi] || (flag_reg[gi] && !(wr_clear && pwdata[gi]));
        end
    endgenerate

    // next values keep the request with its flag
    assign irq_next = |(flag_next & ~mask_next);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            // ready idles high: no false edge after reset
            fr_prev_reg <= 1'b1;
            cnt_prev_reg <= '0;
            flag_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            fr_prev_reg <= fr_prev_next;
            cnt_prev_reg <= cnt_prev_next;
            flag_reg <= flag_next;
            irq_reg <= irq_next;
        end
    end

    assign nand_irq = irq_reg;

    // read mux
    logic [DATA_W-1:0] status_word;

    always_comb begin
        status_word = '0;
        status_word[EVT_N-1:0] = flag_reg;
        status_word[ST_FLASH_RDY] = flash_ready_sync;
        status_word[ST_STROBE_RDY] = strobe_n_reg;
        status_word[ST_EMPTY] = fifo_empty;
        status_word[ST_AEMPTY] = (fifo_cnt <= CNT_AEMPTY);
        status_word[ST_AFULL] = (fifo_cnt >= CNT_AFULL);
        status_word[ST_FULL] = fifo_full;
        status_word[ST_ERROR] = fifo_locked;
    end

    // clear and test read as zero
    always_comb begin
        prdata = '0;
        if (bus_rd) begin
            case (paddr)
                OFS_STATUS: prdata = status_word;
                OFS_MASK: prdata = {{(DATA_W-EVT_N){1'b0}}, mask_reg};
                // empty or locked reads zero
                OFS_FIFO: prdata = (fifo_empty || fifo_locked) ? '0 : fifo_out;
                OFS_WORDS: prdata = words_reg;
                default: prdata = '0;
            endcase
        end
    end
endmodule // nfi_top

/* File: rtl/nfi_pkg.sv */
// Purpose: shared constants and types of the nand fifo, word counter and event status block
// Assumes: 32-bit register bus with byte offsets, 100 MHz mclk
// Notes: strobe lengths are given directly in mclk cycles
package nfi_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;

    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_MASK = 8'h18;
    localparam logic [7:0] OFS_FIFO = 8'h1C;
    localparam logic [7:0] OFS_WORDS = 8'h20;
    localparam logic [7:0] OFS_CLEAR = 8'h24;
    localparam logic [7:0] OFS_TEST = 8'h28;

    // event flags 6..0 of the status register
    localparam int EVT_N = 7;
    localparam int EV_FLASH_RDY = 0;
    localparam int EV_STROBE_RDY = 1;
    localparam int EV_EMPTY_RDY = 2;
    localparam int EV_LOW = 3;
    localparam int EV_HIGH = 4;
    localparam int EV_FULL = 5;
    localparam int EV_ERR = 6;

    // live status levels
    localparam int ST_FLASH_RDY = 7;
    localparam int ST_STROBE_RDY = 8;
    localparam int ST_EMPTY = 9;
    localparam int ST_AEMPTY = 10;
    localparam int ST_AFULL = 11;
    localparam int ST_FULL = 12;
    localparam int ST_ERROR = 13;

    localparam logic [EVT_N-1:0] MASK_RESET = 7'h7F;
    localparam logic [DATA_W-1:0] WORDS_RESET = 32'h0000_0000;

    localparam int TEST_INVERT = 0;
    localparam int TEST_BLOCK = 1;
    localparam logic [1:0] TEST_RESET = 2'h0;

    localparam int FIFO_DEPTH = 36;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] CNT_FULL = 6'h24;
    localparam logic [CNT_W-1:0] CNT_AFULL = 6'h20;
    localparam logic [CNT_W-1:0] CNT_HIGH_FROM = 6'h1F;
    localparam logic [CNT_W-1:0] CNT_AEMPTY = 6'h04;
    localparam logic [CNT_W-1:0] CNT_LOW_FROM = 6'h05;
    localparam logic [CNT_W-1:0] PTR_LAST = 6'h23;
    localparam logic [DATA_W-1:0] BURST_WORDS = 32'h0000_0020;

    // strobe length in mclk cycles
    localparam int STROBE_CFG_W = 5;
    localparam logic [5:0] STROBE_MIN = 6'h03;
    localparam logic [5:0] STROBE_MAX = 6'h21;

    typedef enum logic [2:0] {
        NFI_IDLE = 3'b001,
        NFI_STROBE = 3'b010,
        NFI_GAP = 3'b100
    } nfi_state_t;
endpackage

/* File: rtl/nfi_fifo.sv */
// Purpose: 36-word data fifo with overflow/underflow lock
// Assumes: push and pop may arrive unqualified; full, empty and lock are checked here
// Notes: the lock is left only through clear or reset_n
`timescale 1ns/10ps
module nfi_fifo (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clear,
    input wire logic push,
    input wire logic pop,
    input wire logic [nfi_pkg::DATA_W-1:0] wdata,
    output logic [nfi_pkg::DATA_W-1:0] rdata,
    output logic [nfi_pkg::CNT_W-1:0] count,
    output logic error_pulse,
    output logic locked
);
    import nfi_pkg::*;

    logic [DATA_W-1:0] mem [0:FIFO_DEPTH-1];
    logic [CNT_W-1:0] wptr_reg, wptr_next;
    logic [CNT_W-1:0] rptr_reg, rptr_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic lock_reg, lock_next;
    logic full, empty, push_ok, pop_ok, err;

    assign full = (cnt_reg == CNT_FULL);
    assign empty = (cnt_reg == '0);
    assign pop_ok = pop && !empty && !lock_reg;
    assign push_ok = push && !lock_reg && (!full || pop_ok);
    assign err = !lock_reg && ((push && full && !pop_ok) || (pop && empty));

    always_comb begin
        wptr_next = wptr_reg;
        rptr_next = rptr_reg;
        cnt_next = cnt_reg;
        lock_next = lock_reg || err;
        if (push_ok) begin
            wptr_next = (wptr_reg == PTR_LAST) ? '0 : wptr_reg + 6'h01;
        end
        if (pop_ok) begin
            rptr_next = (rptr_reg == PTR_LAST) ? '0 : rptr_reg + 6'h01;
        end
        if (push_ok && !pop_ok) begin
            cnt_next = cnt_reg + 6'h01;
        end else if (pop_ok && !push_ok) begin
            cnt_next = cnt_reg - 6'h01;
        end
        if (clear) begin
            wptr_next = '0;
            rptr_next = '0;
            cnt_next = '0;
            lock_next = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg <= '0;
            lock_reg <= 1'b0;
        end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            cnt_reg <= cnt_next;
            lock_reg <= lock_next;
        end
    end

    always_ff @(posedge mclk) begin
        if (push_ok && !clear) begin
            mem[wptr_reg] <= wdata;
        end
    end

    assign rdata = mem[rptr_reg];
    assign count = cnt_reg;
    assign error_pulse = err && !clear;
    assign locked = lock_reg;
endmodule // nfi_fifo

/* File: rtl/nfi_buf.sv */
// Purpose: two-entry buffer between the fifo and the flash strobe engine
// Assumes: one clock, valid/ready on both sides
// Notes: out_data always comes from the head flop
`timescale 1ns/10ps
module nfi_buf (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [nfi_pkg::DATA_W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [nfi_pkg::DATA_W-1:0] out_data
);
    import nfi_pkg::*;

    logic [DATA_W-1:0] e0_reg, e0_next, e1_reg, e1_next;
    logic [1:0] cnt_reg, cnt_next, cnt_left;
    logic take, give;

    assign in_ready = (cnt_reg != 2'h2);
    assign out_valid = (cnt_reg != 2'h0);
    assign take = in_valid && in_ready;
    assign give = out_valid && out_ready;
    assign cnt_left = cnt_reg - {1'b0, give};

    always_comb begin
        e0_next = e0_reg;
        e1_next = e1_reg;
        if (give) begin
            e0_next = e1_reg;
        end
        if (take) begin
            if (cnt_left == 2'h0) begin
                e0_next = in_data;
            end else begin
                e1_next = in_data;
            end
        end
        cnt_next = flush ? 2'h0 : cnt_left + {1'b0, take};
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            e0_reg <= '0;
            e1_reg <= '0;
            cnt_reg <= 2'h0;
        end else begin
            e0_reg <= e0_next;
            e1_reg <= e1_next;
            cnt_reg <= cnt_next;
        end
    end

    assign out_data = e0_reg;
endmodule // nfi_buf

/* File: testbench/nfi_top_sva.sv */
// Purpose: concurrent checks on the ports of nfi_top
// Assumes: one mclk domain, reset_n asynchronous and active low
// Notes: mask and block bits are mirrored from bus writes
`timescale 1ns/10ps
module nfi_chk (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [nfi_pkg::ADDR_W-1:0] paddr,
    input wire logic [nfi_pkg::DATA_W-1:0] pwdata,
    input wire logic xfer_write,
    input wire logic flash_ready_sync,
    input wire logic [nfi_pkg::DATA_W-1:0] flash_wdata,
    input wire logic rw_strobe_n,
    input wire logic words_busy,
    input wire logic nand_irq
);
    import nfi_pkg::*;
    logic [EVT_N-1:0] mask_reg;
    logic block_reg;
    logic wr_acc;
    logic words_wr;
    assign wr_acc = psel && penable && pwrite;
    assign words_wr = wr_acc && paddr == OFS_WORDS;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mask_reg <= MASK_RESET;
            block_reg <= 1'b0;
        end else begin
            if (wr_acc && paddr == OFS_MASK) begin
                mask_reg <= pwdata[EVT_N-1:0];
            end
            if (wr_acc && paddr == OFS_TEST) begin
                block_reg <= pwdata[TEST_BLOCK];
            end
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    property p_strobe_len;
        $fell(rw_strobe_n) |-> !rw_strobe_n [*3] ##[1:31] rw_strobe_n;
    endproperty
    a_strobe_len: assert property (p_strobe_len) else $error("strobe length out of range");
    property p_no_xfer;
        (!words_busy) [*2] ##0 rw_strobe_n |=> rw_strobe_n;
    endproperty
    a_no_xfer: assert property (p_no_xfer) else $error("strobe with zero word count");
    property p_block;
        block_reg [*2] ##0 rw_strobe_n |=> rw_strobe_n;
    endproperty
    a_block: assert property (p_block) else $error("strobe while internal access blocked");
    property p_wdata;
        !rw_strobe_n && !$past(rw_strobe_n) && xfer_write |-> $stable(flash_wdata);
    endproperty
    a_wdata: assert property (p_wdata) else $error("write data moved during strobe");
    property p_busy_fall;
        $fell(words_busy) |-> $rose(rw_strobe_n) || $past(words_wr);
    endproperty
    a_busy_fall: assert property (p_busy_fall) else $error("word count hit zero without strobe end");
    property p_empty_irq;
        $rose(rw_strobe_n) && $fell(words_busy) && !mask_reg[EV_EMPTY_RDY] |=> nand_irq;
    endproperty
    a_empty_irq: assert property (p_empty_irq) else $error("no request at burst end");
    property p_strobe_irq;
        $rose(rw_strobe_n) && !mask_reg[EV_STROBE_RDY] |=> nand_irq;
    endproperty
    a_strobe_irq: assert property (p_strobe_irq) else $error("no request at strobe end");
    property p_ready_irq;
        $rose(flash_ready_sync) && !mask_reg[EV_FLASH_RDY] |-> ##[1:3] nand_irq;
    endproperty
    a_ready_irq: assert property (p_ready_irq) else $error("no request on flash ready");
    property p_mask_all;
        wr_acc && paddr == OFS_MASK && pwdata[EVT_N-1:0] == MASK_RESET |=> ##1 !nand_irq;
    endproperty
    a_mask_all: assert property (p_mask_all) else $error("request while fully masked");
endmodule // nfi_chk

/* File: testbench/nfi_flash_model.sv */
// Purpose: behavioural nand flash on the strobe side of nfi_top
// Assumes: one word per active low strobe
// Notes: busy for BUSY_CYC cycles after each strobe
`timescale 1ns/10ps
module nfi_flash_model #(
    parameter int BUSY_CYC = 4
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic rw_strobe_n,
    input wire logic xfer_write,
    input wire logic [nfi_pkg::DATA_W-1:0] flash_wdata,
    output logic flash_ready_sync,
    output logic [nfi_pkg::DATA_W-1:0] flash_rdata,
    output logic [nfi_pkg::DATA_W-1:0] wcap,
    output logic wcap_valid
);
    import nfi_pkg::*;
    logic [DATA_W-1:0] k;
    logic prev;
    int busy;
    // outside a strobe the bus shows the inverse so a late sample is caught
    assign flash_rdata = rw_strobe_n ? ~(32'hA500_0000 + k) : 32'hA500_0000 + k;
    assign flash_ready_sync = (busy == 0);
    always @(negedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            k <= '0;
            prev <= 1'b1;
            busy <= 0;
            wcap_valid <= 1'b0;
        end else begin
            prev <= rw_strobe_n;
            wcap_valid <= 1'b0;
            if (!rw_strobe_n) begin
                wcap <= flash_wdata;
            end
            if (rw_strobe_n && !prev) begin
                k <= k + 1;
                busy <= BUSY_CYC;
                wcap_valid <= xfer_write;
            end else if (busy != 0) begin
                busy <= busy - 1;
            end
        end
    end
endmodule // nfi_flash_model

/* File: testbench/nfi_top_tb.sv */
// Purpose: self-checking bench for nfi_top
// Assumes: flash side played by nfi_flash_model
// Notes: reads note expected data in a queue, a monitor compares at the access edge
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module nfi_top_tb;
    import nfi_pkg::*;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fifo_clear = 1'b0, xfer_write = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata, flash_rdata, flash_wdata, wcap, d, e, m;
    logic pready, pslverr, flash_ready_sync, rw_strobe_n, words_busy, nand_irq, wcap_valid;
    logic [STROBE_CFG_W-1:0] strobe_cfg = '0;
    logic [4:0] cfgs [4] = '{5'h00, 5'h1E, 5'h1F, 5'h07};
    logic [DATA_W-1:0] rq[$], mq[$], wq[$], fq[$];
    logic s, sq[$];
    int n_mismatch = 0, checks = 0, seed = 26, nrd = 0;
    always #5 mclk = ~mclk;
    nfi_top uut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fifo_clear(fifo_clear), .xfer_write(xfer_write), .strobe_cfg(strobe_cfg),
        .flash_ready_sync(flash_ready_sync), .flash_rdata(flash_rdata), .flash_wdata(flash_wdata),
        .rw_strobe_n(rw_strobe_n), .words_busy(words_busy), .nand_irq(nand_irq));
    nfi_flash_model fl (.mclk(mclk), .reset_n(reset_n), .rw_strobe_n(rw_strobe_n), .xfer_write(xfer_write),
        .flash_wdata(flash_wdata), .flash_ready_sync(flash_ready_sync), .flash_rdata(flash_rdata),
        .wcap(wcap), .wcap_valid(wcap_valid));
    always @(posedge mclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0 && rq.size() > 0) begin
            e = rq.pop_front();
            m = mq.pop_front();
            s = sq.pop_front();
            `CHK("prdata", e & m, prdata & m)
            `CHK("pslverr", s, pslverr)
            `CHK("pready", 1'b1, pready)
        end
        if (wcap_valid === 1'b1 && wq.size() > 0) begin
            e = wq.pop_front();
            `CHK("flash_wdata", e, wcap)
        end
    end
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] v);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= v;
        @(negedge mclk) penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        @(negedge mclk) psel <= 1'b0;
        penable <= 1'b0;
        @(negedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] mk);
        rq.push_back(v);
        mq.push_back(mk);
        sq.push_back(!(a inside {OFS_STATUS, OFS_MASK, OFS_FIFO, OFS_WORDS, OFS_CLEAR, OFS_TEST}));
        bus(1'b0, a, 32'h0);
    endtask
    task automatic push(input int n);
        for (int i = 0; i < n; i++) begin
            d = $random(seed);
            fq.push_back(d);
            bus(1'b1, OFS_FIFO, d);
        end
    endtask
    task automatic clr_fifo;
        fifo_clear <= 1'b1;
        @(negedge mclk) fifo_clear <= 1'b0;
        @(negedge mclk);
        fq.delete();
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 3000 && words_busy !== 1'b0; i++) @(negedge mclk);
        repeat (10) @(negedge mclk);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge mclk);
        @(negedge mclk) reset_n <= 1'b1;
        @(negedge mclk);
        rd(OFS_MASK, 32'h7F, ALL);
        rd(OFS_WORDS, 32'h0, ALL);
        rd(8'h30, 32'h0, ALL);
        rd(OFS_STATUS, 32'h0000_0780, 32'h0000_3FFF);
        rd(OFS_FIFO, 32'h0, 32'h0);
        rd(OFS_STATUS, 32'h0000_2040, 32'h0000_2040);
        bus(1'b1, OFS_CLEAR, 32'h0);
        rd(OFS_STATUS, 32'h0000_0040, 32'h0000_0040);
        bus(1'b1, OFS_CLEAR, 32'h40);
        rd(OFS_STATUS, 32'h0000_2000, 32'h0000_2040);
        clr_fifo();
        rd(OFS_STATUS, 32'h0000_0200, 32'h0000_2200);
        push(36);
        rd(OFS_STATUS, 32'h0000_1800, 32'h0000_3A00);
        for (int i = 0; i < 36; i++) rd(OFS_FIFO, fq.pop_front(), ALL);
        rd(OFS_STATUS, 32'h0000_0200, 32'h0000_3200);
        push(37);
        rd(OFS_STATUS, 32'h0000_3000, 32'h0000_3000);
        rd(OFS_FIFO, 32'h0, ALL);
        clr_fifo();
        bus(1'b1, OFS_TEST, 32'h1);
        push(1);
        bus(1'b1, OFS_TEST, 32'h0);
        push(1);
        bus(1'b1, OFS_TEST, 32'h1);
        rd(OFS_TEST, 32'h0, ALL);
        rd(OFS_FIFO, fq.pop_front(), ALL);
        rd(OFS_FIFO, ~fq.pop_front(), ALL);
        bus(1'b1, OFS_TEST, 32'h0);
        bus(1'b1, OFS_MASK, 32'h78);
        for (int c = 0; c < 4; c++) begin
            strobe_cfg <= cfgs[c];
            bus(1'b1, OFS_CLEAR, 32'h7F);
            bus(1'b1, OFS_WORDS, 32'(c + 1));
            wait_idle();
            rd(OFS_WORDS, 32'h0, ALL);
            rd(OFS_STATUS, 32'h0000_0006, 32'h0000_0006);
            `CHK("nand_irq", 1'b1, nand_irq)
            for (int i = 0; i <= c; i++) begin
                rd(OFS_FIFO, 32'hA500_0000 + nrd, ALL);
                nrd++;
            end
        end
        xfer_write <= 1'b1;
        strobe_cfg <= 5'($random(seed));
        bus(1'b1, OFS_TEST, 32'h2);
        bus(1'b1, OFS_WORDS, 32'h80);
        rd(OFS_WORDS, 32'h80, ALL);
        push(3);
        wq = fq;
        fq.delete();
        bus(1'b1, OFS_WORDS, 32'h3);
        repeat (40) @(negedge mclk);
        rd(OFS_WORDS, 32'h3, ALL);
        bus(1'b1, OFS_TEST, 32'h0);
        wait_idle();
        rd(OFS_WORDS, 32'h0, ALL);
        `CHK("words sent", 0, wq.size())
        bus(1'b1, OFS_CLEAR, 32'h7F);
        repeat (3) @(negedge mclk);
        `CHK("nand_irq", 1'b0, nand_irq)
        bus(1'b1, OFS_MASK, 32'h7F);
        rd(OFS_MASK, 32'h7F, ALL);
        summarize();
    end
endmodule // nfi_top_tb
bind nfi_top nfi_chk chk (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .xfer_write(xfer_write), .flash_ready_sync(flash_ready_sync),
    .flash_wdata(flash_wdata), .rw_strobe_n(rw_strobe_n), .words_busy(words_busy), .nand_irq(nand_irq));
